/* File: dv/encoder_marker_capture_tb_top.sv */
// self-checking bench for the encoder marker capture block
// assumes the register bus contract of the block: one-cycle requests, data one cycle later
`timescale 1ns/100ps
module encoder_marker_capture_tb_top
  import encoder_marker_pkg::*;
;
  // ****************************************
  // clock, reset, wiring
  // ****************************************
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  bus_req_t bus_req = '0;
  pins_t pins;
  logic quad_pulse, count_up, loop_timeout;
  logic [15:0] rdata;
  logic [31:0] pos_count;
  logic loop_irq, err_irq, cap_irq;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] st;
  pins_t snap;

  always #25 clk_sys_in = ~clk_sys_in;

  encoder_marker_capture i_encoder_marker_capture (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_req_in(bus_req), .pins_in(pins),
    .quad_pulse_in(quad_pulse), .count_up_in(count_up), .loop_timeout_in(loop_timeout),
    .bus_rdata_out(rdata), .position_count_out(pos_count), .loop_irq_out(loop_irq),
    .error_irq_out(err_irq), .capture_interrupt_out(cap_irq)
  );

  encoder_model i_encoder_model (
    .clk_in(clk_sys_in), .pins_out(pins), .quad_pulse_out(quad_pulse),
    .count_up_out(count_up), .loop_timeout_out(loop_timeout)
  );

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys_in);
    bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk_sys_in);
    bus_req = '0;
  endtask

  // read data lands one cycle after the request edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_sys_in);
    bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(negedge clk_sys_in);
    bus_req = '0;
    d = rdata;
  endtask

  // high half first, low half commits
  task automatic w32(input logic [7:0] lo, input logic [31:0] v);
    wr(lo + 8'h01, v[31:16]);
    wr(lo, v[15:0]);
  endtask

  // low half first, it freezes the high half; back to back, read strobe held
  task automatic c32(input logic [7:0] lo, input logic [31:0] exp, input string what);
    logic [15:0] l, h;
    @(negedge clk_sys_in);
    bus_req = '{rd: 1'b1, wr: 1'b0, addr: lo, wdata: 16'h0000};
    @(negedge clk_sys_in);
    l = rdata;
    bus_req.addr = lo + 8'h01;
    @(negedge clk_sys_in);
    bus_req = '0;
    h = rdata;
    check({h, l}, exp, what);
  endtask

  task automatic c_st(input int pos, input logic exp, input string what);
    rd(ADDR_STATUS, st);
    check(32'(st[pos]), 32'(exp), what);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd(ADDR_CONTROL, st);
    check(32'(st), 32'h0000_0000, "control reset");
    rd(ADDR_STATUS, st);
    check(32'(st), 32'h0000_0004, "status reset");
    c32(ADDR_COUNT_LO, 32'h0000_0000, "count reset");
    c32(ADDR_ZCAP_LO, 32'h0000_0000, "zero capture reset");
    c32(ADDR_SCAP_LO, 32'h0000_0000, "strobe capture reset");
    c32(ADDR_MAX_LO, 32'h0000_0000, "max reset");
    rd(8'h0F, st);
    check(32'(st), 32'h0000_0000, "unmapped read");
  endtask

  task automatic t_init();
    w32(ADDR_MAX_LO, 32'h0001_0003);
    c_st(ST_NOT_INIT, 1'b0, "init flag");
    c32(ADDR_MAX_LO, 32'h0001_0003, "max value");
    wr(ADDR_COUNT_HI, 16'h0001);
    c32(ADDR_COUNT_LO, 32'h0000_0000, "high half alone");
    wr(ADDR_COUNT_LO, 16'h0000);
    c32(ADDR_COUNT_LO, 32'h0001_0000, "count load");
    check(pos_count, 32'h0001_0000, "count port");
  endtask

  // a step between the two halves must not tear the read
  task automatic t_wrap();
    i_encoder_model.step(1'b1, 3);
    rd(ADDR_COUNT_LO, st);
    check(32'(st), 32'h0000_0003, "count low");
    i_encoder_model.step(1'b1, 1);
    rd(ADDR_COUNT_HI, st);
    check(32'(st), 32'h0000_0001, "frozen high");
    c32(ADDR_COUNT_LO, 32'h0000_0000, "wrap up");
    i_encoder_model.step(1'b0, 1);
    c32(ADDR_COUNT_LO, 32'h0001_0003, "wrap down");
  endtask

  task automatic t_zcap_edge();
    i_encoder_model.set_pin(2, 1'b1, 1'b1);
    c32(ADDR_ZCAP_LO, 32'h0001_0003, "zero edge capture");
    c32(ADDR_COUNT_LO, 32'h0001_0003, "counter untouched");
    c_st(ST_ZCAP, 1'b1, "zero capture flag");
    c_st(ST_SCAP, 1'b0, "strobe flag idle");
    check(32'(cap_irq), 32'h1, "capture irq held");
    wr(ADDR_ZCAP_LO, 16'h1234);
    c32(ADDR_ZCAP_LO, 32'h0001_0003, "capture read only");
    wr(ADDR_STATUS, 16'h0040);
    check(32'(cap_irq), 32'h0, "capture irq cleared");
    i_encoder_model.set_pin(2, 1'b0, 1'b1);
  endtask

  task automatic t_zcap_quad();
    wr(ADDR_CONTROL, 16'h0080);
    i_encoder_model.step(1'b0, 2);
    i_encoder_model.set_pin(2, 1'b1, 1'b1);
    c32(ADDR_ZCAP_LO, 32'h0001_0003, "no capture at edge");
    i_encoder_model.step(1'b1, 1);
    c32(ADDR_ZCAP_LO, 32'h0001_0001, "capture on pulse up");
    i_encoder_model.set_pin(2, 1'b0, 1'b0);
    i_encoder_model.step(1'b0, 1);
    c32(ADDR_ZCAP_LO, 32'h0001_0002, "capture on pulse down");
    wr(ADDR_STATUS, 16'h0040);
  endtask

  task automatic t_scap();
    wr(ADDR_CONTROL, 16'h0000);
    i_encoder_model.set_pin(3, 1'b1, 1'b1);
    c32(ADDR_SCAP_LO, 32'h0001_0001, "strobe rise capture");
    c_st(ST_SCAP, 1'b1, "strobe flag");
    check(32'(cap_irq), 32'h1, "strobe irq");
    i_encoder_model.set_pin(3, 1'b0, 1'b1);
    wr(ADDR_STATUS, 16'h0080);
    i_encoder_model.step(1'b0, 1);
    wr(ADDR_CONTROL, 16'h0100);
    i_encoder_model.set_pin(3, 1'b1, 1'b0);
    c32(ADDR_SCAP_LO, 32'h0001_0001, "rise ignored down");
    i_encoder_model.set_pin(3, 1'b0, 1'b0);
    c32(ADDR_SCAP_LO, 32'h0001_0000, "fall capture down");
    wr(ADDR_STATUS, 16'h0080);
  endtask

  task automatic t_check();
    wr(ADDR_CONTROL, 16'h000A);
    w32(ADDR_COUNT_LO, 32'h0001_0003);
    i_encoder_model.set_pin(2, 1'b1, 1'b1);
    i_encoder_model.step(1'b1, 1);
    c_st(ST_COUNT_ERR, 1'b0, "match no error");
    i_encoder_model.set_pin(2, 1'b0, 1'b1);
    w32(ADDR_COUNT_LO, 32'h0000_0005);
    i_encoder_model.set_pin(2, 1'b1, 1'b1);
    i_encoder_model.step(1'b1, 1);
    c_st(ST_COUNT_ERR, 1'b1, "mismatch error");
    check(32'(err_irq), 32'h1, "error irq");
    c32(ADDR_COUNT_LO, 32'h0000_0000, "reset to zero");
    i_encoder_model.step(1'b1, 2);
    c32(ADDR_COUNT_LO, 32'h0000_0002, "counts on");
    i_encoder_model.set_pin(2, 1'b0, 1'b1);
    w32(ADDR_COUNT_LO, 32'h0001_0003);
    i_encoder_model.set_pin(2, 1'b1, 1'b1);
    i_encoder_model.step(1'b1, 1);
    c_st(ST_COUNT_ERR, 1'b0, "error cleared");
    check(32'(err_irq), 32'h0, "error irq low");
    w32(ADDR_COUNT_LO, 32'h0000_0005);
    i_encoder_model.set_pin(2, 1'b0, 1'b0);
    i_encoder_model.step(1'b0, 1);
    c32(ADDR_COUNT_LO, 32'h0001_0003, "reset to max");
    wr(ADDR_STATUS, 16'h0001);
    check(32'(err_irq), 32'h0, "error w1c");
  endtask

  task automatic t_north();
    wr(ADDR_MAX_LO, 16'h0003);
    c_st(ST_FIRST_ZERO, 1'b0, "first zero cleared");
    wr(ADDR_CONTROL, 16'h0006);
    w32(ADDR_COUNT_LO, 32'h0000_0007);
    i_encoder_model.set_pin(2, 1'b1, 1'b1);
    i_encoder_model.step(1'b1, 1);
    c_st(ST_FIRST_ZERO, 1'b1, "first zero seen");
    c32(ADDR_COUNT_LO, 32'h0000_0000, "first reset");
    i_encoder_model.set_pin(2, 1'b0, 1'b1);
    i_encoder_model.step(1'b1, 3);
    i_encoder_model.set_pin(2, 1'b1, 1'b1);
    i_encoder_model.step(1'b1, 1);
    c32(ADDR_COUNT_LO, 32'h0000_0004, "no second reset");
    i_encoder_model.set_pin(2, 1'b0, 1'b1);
  endtask

  // live bits follow the pins, snapshot bits only move on a count low read
  task automatic t_pins();
    rd(ADDR_COUNT_LO, st);
    snap = pins;
    i_encoder_model.set_pin(3, 1'b1, 1'b1);
    rd(ADDR_STATUS, st);
    check(32'(st[11:8]), 32'(pins), "live pins");
    check(32'(st[15:12]), 32'(snap), "held snapshot");
    rd(ADDR_COUNT_LO, st);
    rd(ADDR_STATUS, st);
    check(32'(st[15:12]), 32'(pins), "new snapshot");
    i_encoder_model.set_pin(3, 1'b0, 1'b1);
  endtask

  task automatic t_loop();
    i_encoder_model.timeout();
    repeat (6) @(negedge clk_sys_in);
    check(32'(loop_irq), 32'h1, "loop irq held");
    c_st(ST_LOOP_TIMEOUT, 1'b1, "loop flag");
    wr(ADDR_STATUS, 16'h0020);
    check(32'(loop_irq), 32'h0, "loop irq cleared");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(negedge clk_sys_in);
    rst_in = 1'b0;
    t_reset();
    t_init();
    t_wrap();
    t_zcap_edge();
    t_zcap_quad();
    t_scap();
    t_check();
    t_north();
    t_pins();
    t_loop();
    report_and_stop();
  end
endmodule

/* File: dv/encoder_model.sv */
// encoder partner: quadrature edges, marker pins and loop timer pulses
// assumes the bench calls its tasks; every output changes at a falling edge
`timescale 1ns/100ps
module encoder_model
  import encoder_marker_pkg::*;
(
  input wire logic clk_in,
  output pins_t pins_out,
  output logic quad_pulse_out,
  output logic count_up_out,
  output logic loop_timeout_out
);
  // ****************************************
  // state and start-up levels
  // ****************************************
  logic [1:0] phase_q;

  // idle encoder, reverse direction so the direction status bit starts low
  initial begin
    pins_out = '0;
    quad_pulse_out = 1'b0;
    count_up_out = 1'b0;
    loop_timeout_out = 1'b0;
    phase_q = 2'b00;
  end

  // ****************************************
  // stimulus tasks
  // ****************************************
  // gray sequence on a and b, so only one pin moves per counted edge
  task automatic step(input logic up, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      count_up_out = up;
      phase_q = up ? phase_q + 2'd1 : phase_q - 2'd1;
      pins_out.quadrature_a = phase_q[1];
      pins_out.quadrature_b = phase_q[1] ^ phase_q[0];
      quad_pulse_out = 1'b1;
      @(negedge clk_in);
      quad_pulse_out = 1'b0;
    end
  endtask

  // direction settles a cycle before the pin moves, as on a real shaft
  task automatic set_pin(input int idx, input logic v, input logic up);
    @(negedge clk_in);
    count_up_out = up;
    @(negedge clk_in);
    pins_out[idx] = v;
    @(negedge clk_in);
  endtask

  task automatic timeout();
    @(negedge clk_in);
    loop_timeout_out = 1'b1;
    @(negedge clk_in);
    loop_timeout_out = 1'b0;
  endtask
endmodule

/* File: src/encoder_marker_capture.sv */
// encoder unit: position counter, marker captures, zero reset, error check,
// pin status and sticky interrupts behind a 16-bit register bus
// assumes filtered pins, quadrature pulse and direction come from logic on clk_sys_in
`timescale 1ns/100ps

// Function
// - control bit 7 clear: zero-marker rising edge copies count into zero capture
// - bit 7 set, counting up: capture on first quadrature pulse after zero rise
// - bit 7 set, counting down: capture on first quadrature pulse after zero fall
// - marker captures never change the up/down counter itself
// - control bit 8 clear: strobe rising edge copies count into strobe capture
// - bit 8 set: strobe captures at its edge, rising up, falling down
// - both captures are 32-bit read-only; control bits 7 and 8 reset to zero
// - single-north mode resets count only at first zero marker, needs zero-reset
// - status bit 3 sets at first zero marker; single-north bit resets zero
// - with check and zero-reset, mismatch at zero marker sets status bit 0
// - counting continues normally after a count error
// - later matching zero marker clears status bit 0; check bit resets zero
// - status bits 8-11 follow the filtered input levels continuously
// - status bits 12-15 snapshot inputs only when count low half is read
// - three interrupt outputs from four sticky bits, cleared by writing one
// - loop timeout sets status bit 5 and loop interrupt until cleared
// - either capture update raises one capture interrupt, two bits tell which
// - each 32-bit register is two 16-bit halves, low half at lower address
// - upper halves of 32-bit registers reset to zero
// - high half written first; maximum low write commits, initialises, clears bit 2
// - only a count low-half write loads the counter with the assembled value
// - reading a count or capture low half freezes its upper half for the following read
// - zero-reset resets count at zero marker: zero forward, maximum reverse
// - zero marker is the rising edge forward, falling edge in reverse
module encoder_marker_capture
  import encoder_marker_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire bus_req_t bus_req_in,
  input wire pins_t pins_in,
  input wire logic quad_pulse_in,
  input wire logic count_up_in,
  input wire logic loop_timeout_in,
  output logic [15:0] bus_rdata_out,
  output logic [31:0] position_count_out,
  output logic loop_irq_out,
  output logic error_irq_out,
  output logic capture_interrupt_out
);

  // ****************************************
  // state
  // ****************************************
  logic [15:0] control_q;
  logic [15:0] status_q;
  logic [31:0] count_q;
  logic [31:0] max_q;
  logic [31:0] zcap_q;
  logic [31:0] scap_q;
  logic [15:0] count_hi_wr_q;
  logic [15:0] max_hi_wr_q;
  logic [15:0] count_hi_rd_q;
  logic [15:0] zcap_hi_rd_q;
  logic [15:0] scap_hi_rd_q;
  pins_t pins_prev_q;
  logic zero_pend_q;
  logic zcap_arm_q;
  logic first_reset_done_q;
  logic [15:0] rdata_d;

  // next count in the running direction with rollover at the maximum
  function automatic logic [31:0] step_count(input logic [31:0] cur, input logic [31:0] max,
                                             input logic up);
    if (up) begin
      step_count = (cur == max) ? 32'h0000_0000 : cur + 32'h0000_0001;
    end else begin
      step_count = (cur == 32'h0000_0000) ? max : cur - 32'h0000_0001;
    end
  endfunction

  // ****************************************
  // decode and events
  // ****************************************
  logic wr_ctl, wr_st, wr_cnt_lo, wr_cnt_hi, wr_max_lo, wr_max_hi;
  logic rd_cnt_lo, rd_zcap_lo, rd_scap_lo;
  logic z_rise, z_fall, s_rise, s_fall, zero_mark;
  logic zero_enable, zero_reset_now, check_now, count_mismatch;
  logic zcap_now, scap_now;
  logic [31:0] count_natural;
  logic [31:0] expected;

  assign wr_ctl = bus_req_in.wr && bus_req_in.addr == ADDR_CONTROL;
  assign wr_st = bus_req_in.wr && bus_req_in.addr == ADDR_STATUS;
  assign wr_cnt_lo = bus_req_in.wr && bus_req_in.addr == ADDR_COUNT_LO;
  assign wr_cnt_hi = bus_req_in.wr && bus_req_in.addr == ADDR_COUNT_HI;
  assign wr_max_lo = bus_req_in.wr && bus_req_in.addr == ADDR_MAX_LO;
  assign wr_max_hi = bus_req_in.wr && bus_req_in.addr == ADDR_MAX_HI;
  assign rd_cnt_lo = bus_req_in.rd && bus_req_in.addr == ADDR_COUNT_LO;
  assign rd_zcap_lo = bus_req_in.rd && bus_req_in.addr == ADDR_ZCAP_LO;
  assign rd_scap_lo = bus_req_in.rd && bus_req_in.addr == ADDR_SCAP_LO;

  // marker edges against the previous filtered level
  assign z_rise = pins_in.zero_marker && !pins_prev_q.zero_marker;
  assign z_fall = !pins_in.zero_marker && pins_prev_q.zero_marker;
  assign s_rise = pins_in.strobe_marker && !pins_prev_q.strobe_marker;
  assign s_fall = !pins_in.strobe_marker && pins_prev_q.strobe_marker;
  assign zero_mark = count_up_in ? z_rise : z_fall;

  // zero reset acts on the quadrature pulse after the marker
  assign zero_enable = control_q[CTL_ZERO_RESET];
  assign zero_reset_now = zero_pend_q && quad_pulse_in && zero_enable
                          && !(control_q[CTL_SINGLE_NORTH] && first_reset_done_q);
  assign expected = count_up_in ? 32'h0000_0000 : max_q;
  // compare the naturally stepped count, before the reset overrides it
  assign count_natural = step_count(count_q, max_q, count_up_in);
  assign check_now = zero_pend_q && quad_pulse_in && zero_enable && control_q[CTL_CHECK];
  assign count_mismatch = count_natural != expected;

  // capture strobes
  assign zcap_now = control_q[CTL_ZCAP_QUAD] ? (zcap_arm_q && quad_pulse_in) : z_rise;
  assign scap_now = control_q[CTL_SCAP_DIR] ? (count_up_in ? s_rise : s_fall) : s_rise;

  // ****************************************
  // marker tracking
  // ****************************************
  // previous pin levels for edge detection
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pins_prev_q <= '0;
    end else begin
      pins_prev_q <= pins_in;
    end
  end

  // pending zero reset, cleared when consumed or on initialisation
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      zero_pend_q <= 1'b0;
      first_reset_done_q <= 1'b0;
    end else if (wr_max_lo) begin
      zero_pend_q <= 1'b0;
      first_reset_done_q <= 1'b0;
    end else begin
      if (zero_mark && zero_enable) begin
        zero_pend_q <= 1'b1;
      end else if (quad_pulse_in) begin
        zero_pend_q <= 1'b0;
      end
      if (zero_reset_now) begin
        first_reset_done_q <= 1'b1;
      end
    end
  end

  // zero capture arm in quadrature mode only, so an edge seen in edge mode
  // cannot leave a stale arm behind; direction picks the edge
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      zcap_arm_q <= 1'b0;
    end else if (control_q[CTL_ZCAP_QUAD] && (count_up_in ? z_rise : z_fall)) begin
      zcap_arm_q <= 1'b1;
    end else if (quad_pulse_in) begin
      zcap_arm_q <= 1'b0;
    end
  end

  // ****************************************
  // registers written by software
  // ****************************************
  // control; capture mode bits and mode bits reset to zero
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      control_q <= CONTROL_RESET;
    end else if (wr_ctl) begin
      control_q <= bus_req_in.wdata;
    end
  end

  // staged high halves; only the low-half write commits
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      count_hi_wr_q <= HALF_RESET;
      max_hi_wr_q <= HALF_RESET;
      max_q <= MAX_RESET;
    end else begin
      if (wr_cnt_hi) begin
        count_hi_wr_q <= bus_req_in.wdata;
      end
      if (wr_max_hi) begin
        max_hi_wr_q <= bus_req_in.wdata;
      end
      if (wr_max_lo) begin
        max_q <= {max_hi_wr_q, bus_req_in.wdata};
      end
    end
  end

  // ****************************************
  // position counter
  // ****************************************
  // bus load beats a quadrature step; captures never touch it
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= COUNT_RESET;
    end else if (wr_cnt_lo) begin
      count_q <= {count_hi_wr_q, bus_req_in.wdata};
    end else if (zero_reset_now) begin
      count_q <= expected;
    end else if (quad_pulse_in) begin
      count_q <= count_natural;
    end
  end

  // ****************************************
  // capture registers
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      zcap_q <= COUNT_RESET;
      scap_q <= COUNT_RESET;
    end else begin
      if (zcap_now) begin
        zcap_q <= count_q;
      end
      if (scap_now) begin
        scap_q <= count_q;
      end
    end
  end

  // ****************************************
  // status and interrupts
  // ****************************************
  logic [15:0] status_d;
  always_comb begin
    status_d = status_q;
    // write one clears; a same-cycle event below wins over the clear
    if (wr_st) begin
      status_d = status_q & ~(bus_req_in.wdata & 16'h00E1);
    end
    status_d[ST_DIR_UP] = count_up_in;
    status_d[4] = 1'b0;
    if (wr_max_lo) begin
      status_d[ST_NOT_INIT] = 1'b0;
      status_d[ST_FIRST_ZERO] = 1'b0;
    end
    if (zero_mark && zero_enable) begin
      status_d[ST_FIRST_ZERO] = 1'b1;
    end
    if (check_now) begin
      status_d[ST_COUNT_ERR] = count_mismatch;
    end
    if (loop_timeout_in) begin
      status_d[ST_LOOP_TIMEOUT] = 1'b1;
    end
    if (zcap_now) begin
      status_d[ST_ZCAP] = 1'b1;
    end
    if (scap_now) begin
      status_d[ST_SCAP] = 1'b1;
    end
    status_d[ST_LIVE_LSB +: 4] = pins_in;
    if (rd_cnt_lo) begin
      status_d[ST_SNAP_LSB +: 4] = pins_in;
    end
  end

  // not-initialised bit stands until the maximum is committed
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // interrupt outputs track the sticky bits in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      loop_irq_out <= 1'b0;
      error_irq_out <= 1'b0;
      capture_interrupt_out <= 1'b0;
    end else begin
      loop_irq_out <= status_d[ST_LOOP_TIMEOUT];
      error_irq_out <= status_d[ST_COUNT_ERR];
      capture_interrupt_out <= status_d[ST_ZCAP] | status_d[ST_SCAP];
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // count and capture high halves read from a copy frozen by the low-half read; maximum high reads max_q directly
  always_comb begin
    case (bus_req_in.addr)
      ADDR_CONTROL: rdata_d = control_q;
      ADDR_STATUS: rdata_d = status_q;
      ADDR_COUNT_LO: rdata_d = count_q[15:0];
      ADDR_COUNT_HI: rdata_d = count_hi_rd_q;
      ADDR_ZCAP_LO: rdata_d = zcap_q[15:0];
      ADDR_ZCAP_HI: rdata_d = zcap_hi_rd_q;
      ADDR_SCAP_LO: rdata_d = scap_q[15:0];
      ADDR_SCAP_HI: rdata_d = scap_hi_rd_q;
      ADDR_MAX_LO: rdata_d = max_q[15:0];
      ADDR_MAX_HI: rdata_d = max_q[31:16];
      default: rdata_d = 16'h0000;
    endcase
  end

  // frozen high halves
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      count_hi_rd_q <= HALF_RESET;
      zcap_hi_rd_q <= HALF_RESET;
      scap_hi_rd_q <= HALF_RESET;
    end else begin
      if (rd_cnt_lo) begin
        count_hi_rd_q <= count_q[31:16];
      end
      if (rd_zcap_lo) begin
        zcap_hi_rd_q <= zcap_q[31:16];
      end
      if (rd_scap_lo) begin
        scap_hi_rd_q <= scap_q[31:16];
      end
    end
  end

  // read data one cycle after the strobe; count mirrored out for the timers
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bus_rdata_out <= 16'h0000;
      position_count_out <= COUNT_RESET;
    end else begin
      if (bus_req_in.rd) begin
        bus_rdata_out <= rdata_d;
      end
      position_count_out <= count_q;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  zcap_direct_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !control_q[CTL_ZCAP_QUAD] && z_rise |=> zcap_q == $past(count_q))
    else $error("zero capture missed the rising edge");

  zcap_quad_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    control_q[CTL_ZCAP_QUAD] && count_up_in && z_rise && !quad_pulse_in ##1
    (quad_pulse_in && !z_rise && !z_fall && control_q[CTL_ZCAP_QUAD]) |=> zcap_q == $past(count_q))
    else $error("zero capture missed the quadrature pulse");

  scap_dir_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    control_q[CTL_SCAP_DIR] && !count_up_in && s_fall |=> scap_q == $past(count_q) && status_q[ST_SCAP])
    else $error("strobe capture missed the falling edge");

  count_load_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_cnt_lo |=> count_q == {$past(count_hi_wr_q), $past(bus_req_in.wdata)})
    else $error("count low write did not load counter");

  count_step_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    quad_pulse_in && !wr_cnt_lo && !zero_reset_now |=> count_q == $past(count_natural))
    else $error("counter step disturbed");

  count_error_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    check_now && count_mismatch |=> status_q[ST_COUNT_ERR] && error_irq_out)
    else $error("count error not flagged");

  loop_irq_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    loop_timeout_in |=> loop_irq_out && status_q[ST_LOOP_TIMEOUT])
    else $error("loop timeout interrupt missing");

  irq_sticky_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    capture_interrupt_out && !wr_st |=> capture_interrupt_out)
    else $error("capture interrupt dropped without clear");

  max_init_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_max_lo |=> !status_q[ST_NOT_INIT] && max_q == {$past(max_hi_wr_q), $past(bus_req_in.wdata)})
    else $error("maximum commit failed");

  snap_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !rd_cnt_lo |=> $stable(status_q[15:12]))
    else $error("pin snapshot changed without count read");

  live_pins_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    1'b1 |=> status_q[11:8] == $past(pins_in))
    else $error("live pin bits lag");

  hi_freeze_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    rd_cnt_lo ##1 (bus_req_in.rd && bus_req_in.addr == ADDR_COUNT_HI) |=> bus_rdata_out == $past(count_q[31:16], 2))
    else $error("count high half not frozen");

endmodule

/* File: src/encoder_marker_pkg.sv */
// package for the encoder marker capture block
// assumes a 16-bit peripheral i/o bus on the system clock, word addresses
package encoder_marker_pkg;

  // ****************************************
  // register word addresses
  // ****************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_COUNT_LO = 8'h02;
  localparam logic [7:0] ADDR_COUNT_HI = 8'h03;
  localparam logic [7:0] ADDR_ZCAP_LO = 8'h06;
  localparam logic [7:0] ADDR_ZCAP_HI = 8'h07;
  localparam logic [7:0] ADDR_SCAP_LO = 8'h08;
  localparam logic [7:0] ADDR_SCAP_HI = 8'h09;
  localparam logic [7:0] ADDR_MAX_LO = 8'h0C;
  localparam logic [7:0] ADDR_MAX_HI = 8'h0D;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int CTL_ZERO_RESET = 1;
  localparam int CTL_SINGLE_NORTH = 2;
  localparam int CTL_CHECK = 3;
  localparam int CTL_ZCAP_QUAD = 7;
  localparam int CTL_SCAP_DIR = 8;

  // ****************************************
  // status field positions
  // ****************************************
  localparam int ST_COUNT_ERR = 0;
  localparam int ST_DIR_UP = 1;
  localparam int ST_NOT_INIT = 2;
  localparam int ST_FIRST_ZERO = 3;
  localparam int ST_LOOP_TIMEOUT = 5;
  localparam int ST_ZCAP = 6;
  localparam int ST_SCAP = 7;
  localparam int ST_LIVE_LSB = 8;
  localparam int ST_SNAP_LSB = 12;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] MAX_RESET = 32'h0000_0000;
  localparam logic [15:0] HALF_RESET = 16'h0000;
  // not-initialised bit stands until the maximum is committed
  localparam logic [15:0] STATUS_RESET = 16'h0004;

  // filtered encoder input levels
  typedef struct packed {
    logic strobe_marker;
    logic zero_marker;
    logic quadrature_b;
    logic quadrature_a;
  } pins_t;

  // one register bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } bus_req_t;

endpackage
